// [rtl/clms_phase_shifter.sv]
// Fine phase shift control and status logic of a clock manager, with Wishbone registers.
// Assumes all clock-like inputs are sampled on clk_i and are much slower than it.
//
// Notes on behaviour
// - Static delay equals fixed amount over 256 times input period.
// - Zero fixed amount keeps phase; positive later, negative earlier.
// - Each enabled step cycle adds or subtracts one fine delay unit.
// - Dynamic range limited to integer of 20 times (period ns minus 3).
// - Change takes up to 100 input plus 3 step cycles; one-cycle completion.
// - Completion means ready; partner waits for it before next request.
// - Step enable, clock and direction each have selectable polarity.
// - Dynamic operations timed on step clock; completion synchronous to it.
// - Manager reset returns accumulated shift to zero.
// - Asynchronous manager reset restores power-on state, zero taps, lock low.
// - Manager reset leaves configuration values untouched.
// - Lock flag high while input and feedback in phase, else low.
// - Status bit 1 flags halted input clock when feedback connected.
// - Status bit 2 flags halted synth clock when synth output connected.
// - Eight-bit status bus; bit 0 and bits 3 to 7 reserved.
// - With hold enabled, startup stays until every lock flag high.
// - Setting picks which of six startup cycles stalls for lock.
// - Fixed amount is signed within minus 255 to plus 255.
// - Mode selects disabled, static or dynamic shifting.
`timescale 1ns/1ps
`default_nettype none
`include "clms_map.svh"

module clms_phase_shifter
    import clms_pkg::*;
#(
    parameter int SHIFT_W     = 12,
    parameter int SETTLE_REF  = `CLMS_SETTLE_REF,
    parameter int LOCK_EDGES  = `CLMS_LOCK_EDGES,
    parameter int HALT_CYCLES = `CLMS_HALT_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 manager_reset_i,
    input  wire logic                 reference_clock_in_i,
    input  wire logic                 feedback_clock_in_i,
    input  wire logic                 synth_clock_mon_i,
    input  wire logic                 shift_step_enable_i,
    input  wire logic                 shift_step_clock_i,
    input  wire logic                 shift_direction_i,
    input  wire logic                 others_phase_lock_flag_i,
    output logic                      shift_complete_o,
    output logic                      phase_lock_flag_o,
    output logic      [7:0]           status_o,
    output logic signed [24:0]        static_delay_ps_o,
    output logic signed [SHIFT_W-1:0] dynamic_steps_o,
    output logic                      user_mode_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [SHIFT_W-1:0] max_steps(input logic [15:0] period_ps);
        logic [15:0] excess;
        excess = 16'h0000;
        if (period_ps > 16'(`CLMS_PERIOD_OFS_PS)) excess = period_ps - 16'(`CLMS_PERIOD_OFS_PS);
        return SHIFT_W'(excess / 16'(`CLMS_STEPS_PS));
    endfunction

    function automatic logic signed [8:0] clamp_fixed(input logic [8:0] raw);
        logic signed [8:0] v;
        v = $signed(raw);
        if (v < -9'sd255) v = -9'sd255;
        return v;
    endfunction

    function automatic logic [7:0] lane(input logic [31:0] d, input int idx);
        return d[idx*8 +: 8];
    endfunction

    // ----------------------------------------------------------------
    // Configuration registers (set to their reset values only by rst_i)
    // ----------------------------------------------------------------
    logic [10:0]       ctrl_ff;
    logic signed [8:0] fixed_ff;
    logic [15:0]       period_ff;
    logic              wr_en;
    logic [31:0]       ctrl_wr;
    logic [31:0]       period_wr;
    logic [31:0]       fixed_wr;
    clms_mode_t        mode;

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    always_comb begin
        ctrl_wr   = {21'h000000, ctrl_ff};
        period_wr = {16'h0000, period_ff};
        fixed_wr  = {23'h000000, fixed_ff};
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
                ctrl_wr[i*8 +: 8]   = lane(wb_dat_i, i);
                period_wr[i*8 +: 8] = lane(wb_dat_i, i);
                fixed_wr[i*8 +: 8]  = lane(wb_dat_i, i);
            end
        end
    end

    // Manager reset does not reach these
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff   <= `CLMS_CTRL_RESET;
            fixed_ff  <= `CLMS_FIXED_RESET;
            period_ff <= `CLMS_PERIOD_RESET;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                `CLMS_OFS_CTRL:   ctrl_ff   <= ctrl_wr[10:0];
                `CLMS_OFS_FIXED:  fixed_ff  <= clamp_fixed(fixed_wr[8:0]);
                `CLMS_OFS_PERIOD: period_ff <= period_wr[15:0];
                default:          ;
            endcase
        end
    end

    // Reserved mode code behaves as disabled
    always_comb begin
        unique case (ctrl_ff[`CLMS_CTRL_MODE_HI:`CLMS_CTRL_MODE_LO])
            2'h1:    mode = CLMS_MODE_STATIC;
            2'h2:    mode = CLMS_MODE_DYNAMIC;
            default: mode = CLMS_MODE_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin sampling and edge detection
    // ----------------------------------------------------------------
    logic ref_ff;
    logic fb_ff;
    logic fx_ff;
    logic step_clk_ff;
    logic step_clk_pol;
    logic ref_edge;
    logic fb_edge;
    logic fx_edge;
    logic step_edge;
    logic step_req;
    logic step_up;

    assign step_clk_pol = shift_step_clock_i ^ ctrl_ff[`CLMS_CTRL_CLK_INV];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_ff      <= 1'b0;
            fb_ff       <= 1'b0;
            fx_ff       <= 1'b0;
            step_clk_ff <= 1'b0;
        end else begin
            ref_ff      <= reference_clock_in_i;
            fb_ff       <= feedback_clock_in_i;
            fx_ff       <= synth_clock_mon_i;
            step_clk_ff <= step_clk_pol;
        end
    end

    assign ref_edge  = reference_clock_in_i && !ref_ff;
    assign fb_edge   = feedback_clock_in_i && !fb_ff;
    assign fx_edge   = synth_clock_mon_i && !fx_ff;
    assign step_edge = step_clk_pol && !step_clk_ff;
    // Step requests only count in dynamic mode; step clock edges still advance a step in progress in any mode
    assign step_req  = step_edge && (mode == CLMS_MODE_DYNAMIC)
                       && (shift_step_enable_i ^ ctrl_ff[`CLMS_CTRL_EN_INV]);
    assign step_up   = shift_direction_i ^ ctrl_ff[`CLMS_CTRL_DIR_INV];

    // ----------------------------------------------------------------
    // Dynamic shift engine
    // ----------------------------------------------------------------
    clms_step_engine #(
        .SHIFT_W    (SHIFT_W),
        .SETTLE_REF (SETTLE_REF)
    ) u_engine (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .mgr_rst_i   (manager_reset_i),
        .step_edge_i (step_edge),
        .step_req_i  (step_req),
        .step_up_i   (step_up),
        .ref_edge_i  (ref_edge),
        .limit_i     (max_steps(period_ff)),
        .shift_o     (dynamic_steps_o),
        .complete_o  (shift_complete_o)
    );

    // ----------------------------------------------------------------
    // Static delay
    // ----------------------------------------------------------------
    logic signed [24:0] static_prod;

    assign static_prod = 25'(fixed_ff) * 25'($signed({1'b0, period_ff}));

    // Truncating divide keeps zero exactly in phase and symmetric sign
    always_ff @(posedge clk_i or posedge manager_reset_i) begin
        if (manager_reset_i) begin
            static_delay_ps_o <= 25'h0000000;
        end else if (rst_i || mode != CLMS_MODE_STATIC) begin
            static_delay_ps_o <= 25'h0000000;
        end else begin
            static_delay_ps_o <= static_prod / 25'(`CLMS_SHIFT_DIV);
        end
    end

    // ----------------------------------------------------------------
    // Lock detection
    // ----------------------------------------------------------------
    logic [7:0] lock_cnt_ff;

    // Needs LOCK_EDGES coincident edges; any lone edge drops lock at once
    always_ff @(posedge clk_i or posedge manager_reset_i) begin
        if (manager_reset_i) begin
            lock_cnt_ff       <= 8'h00;
            phase_lock_flag_o <= 1'b0;
        end else if (rst_i || (ref_edge != fb_edge)) begin
            lock_cnt_ff       <= 8'h00;
            phase_lock_flag_o <= 1'b0;
        end else if (ref_edge && fb_edge) begin
            if (lock_cnt_ff != 8'(LOCK_EDGES)) lock_cnt_ff <= lock_cnt_ff + 8'h01;
            phase_lock_flag_o <= (lock_cnt_ff >= 8'(LOCK_EDGES - 1));
        end
    end

    // ----------------------------------------------------------------
    // Halt detectors and status bus
    // ----------------------------------------------------------------
    logic [15:0] ref_idle_ff;
    logic [15:0] fx_idle_ff;

    always_ff @(posedge clk_i or posedge manager_reset_i) begin
        if (manager_reset_i) begin
            ref_idle_ff <= 16'h0000;
            fx_idle_ff  <= 16'h0000;
        end else if (rst_i) begin
            ref_idle_ff <= 16'h0000;
            fx_idle_ff  <= 16'h0000;
        end else begin
            if (ref_edge) ref_idle_ff <= 16'h0000;
            else if (ref_idle_ff != 16'(HALT_CYCLES)) ref_idle_ff <= ref_idle_ff + 16'h0001;
            if (fx_edge) fx_idle_ff <= 16'h0000;
            else if (fx_idle_ff != 16'(HALT_CYCLES)) fx_idle_ff <= fx_idle_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge manager_reset_i) begin
        if (manager_reset_i) begin
            status_o <= 8'h00;
        end else if (rst_i) begin
            status_o <= 8'h00;
        end else begin
            status_o <= 8'h00;
            status_o[`CLMS_STATUS_IN_HALT] <= ctrl_ff[`CLMS_CTRL_FB_CONN]
                                            && (ref_idle_ff == 16'(HALT_CYCLES));
            status_o[`CLMS_STATUS_FX_HALT] <= ctrl_ff[`CLMS_CTRL_FX_CONN]
                                            && (fx_idle_ff == 16'(HALT_CYCLES));
        end
    end

    // ----------------------------------------------------------------
    // Startup sequencer
    // ----------------------------------------------------------------
    clms_startup_state_t su_ff;
    clms_startup_state_t nxt_su;
    logic [2:0]          su_cycle_ff;
    logic                stall_here;

    assign stall_here = ctrl_ff[`CLMS_CTRL_HOLD]
                        && (su_cycle_ff == ctrl_ff[`CLMS_CTRL_STALL_HI:`CLMS_CTRL_STALL_LO]);

    always_comb begin
        nxt_su = su_ff;
        unique case (su_ff)
            CLMS_SU_CFG:  if (stall_here) nxt_su = CLMS_SU_WAIT;
                          else if (su_cycle_ff == 3'(`CLMS_STARTUP_CYCLES - 1)) nxt_su = CLMS_SU_USER;
            CLMS_SU_WAIT: if (phase_lock_flag_o && others_phase_lock_flag_i) nxt_su = CLMS_SU_CFG;
            CLMS_SU_USER: nxt_su = CLMS_SU_USER;
            default:      nxt_su = CLMS_SU_CFG;
        endcase
    end

    // Startup is a configuration event, so only rst_i restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            su_ff       <= CLMS_SU_CFG;
            su_cycle_ff <= 3'h0;
        end else begin
            su_ff <= nxt_su;
            if (su_ff == CLMS_SU_CFG && !stall_here) su_cycle_ff <= su_cycle_ff + 3'h1;
            else if (su_ff == CLMS_SU_WAIT && nxt_su == CLMS_SU_CFG) su_cycle_ff <= su_cycle_ff + 3'h1;
        end
    end

    assign user_mode_o = (su_ff == CLMS_SU_USER);

    // ----------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped reads return zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h00000000;
            unique case (wb_adr_i)
                `CLMS_OFS_CTRL:   wb_dat_o <= {21'h000000, ctrl_ff};
                `CLMS_OFS_FIXED:  wb_dat_o <= {{23{fixed_ff[8]}}, fixed_ff};
                `CLMS_OFS_PERIOD: wb_dat_o <= {16'h0000, period_ff};
                `CLMS_OFS_STATUS: begin
                    wb_dat_o[7:0]                <= status_o;
                    wb_dat_o[`CLMS_STAT_LOCK]    <= phase_lock_flag_o;
                    wb_dat_o[`CLMS_STAT_USER]    <= user_mode_o;
                    wb_dat_o[`CLMS_STAT_SHIFT_HI:`CLMS_STAT_SHIFT_LO] <= dynamic_steps_o;
                end
                default:          ;
            endcase
        end
    end

endmodule
`default_nettype wire

// [rtl/clms_map.svh]
// Register offsets, field positions, reset values and timing counts of the phase shifter block.
// Included by the package user files; holds definitions only.
`ifndef CLMS_MAP_SVH
`define CLMS_MAP_SVH

`define CLMS_OFS_CTRL        4'h0
`define CLMS_OFS_FIXED       4'h4
`define CLMS_OFS_PERIOD      4'h8
`define CLMS_OFS_STATUS      4'hC

`define CLMS_CTRL_MODE_LO    0
`define CLMS_CTRL_MODE_HI    1
`define CLMS_CTRL_EN_INV     2
`define CLMS_CTRL_CLK_INV    3
`define CLMS_CTRL_DIR_INV    4
`define CLMS_CTRL_HOLD       5
`define CLMS_CTRL_STALL_LO   6
`define CLMS_CTRL_STALL_HI   8
`define CLMS_CTRL_FB_CONN    9
`define CLMS_CTRL_FX_CONN    10

`define CLMS_STAT_LOCK       8
`define CLMS_STAT_USER       9
`define CLMS_STAT_SHIFT_LO   16
`define CLMS_STAT_SHIFT_HI   27

`define CLMS_STATUS_IN_HALT  1
`define CLMS_STATUS_FX_HALT  2

`define CLMS_CTRL_RESET      11'h000
`define CLMS_FIXED_RESET     9'h000
`define CLMS_PERIOD_RESET    16'h1F40
`define CLMS_FIXED_MAX       255
`define CLMS_SHIFT_DIV       256
`define CLMS_PERIOD_OFS_PS   3000
`define CLMS_STEPS_PS        50
`define CLMS_SETTLE_REF      100
`define CLMS_STARTUP_CYCLES  6
`define CLMS_LOCK_EDGES      16
`define CLMS_HALT_NS         1000
`define CLMS_CLK_NS          8
`define CLMS_HALT_CYCLES     (`CLMS_HALT_NS / `CLMS_CLK_NS)

`endif

// [rtl/clms_pkg.sv]
// Types shared by the phase shifter block: shift modes and state encodings.
// Assumes the constants header is included by the user files.
package clms_pkg;

    typedef enum logic [1:0] {
        CLMS_MODE_NONE    = 2'h0,
        CLMS_MODE_STATIC  = 2'h1,
        CLMS_MODE_DYNAMIC = 2'h2
    } clms_mode_t;

    typedef enum logic [3:0] {
        CLMS_ST_IDLE   = 4'h1,
        CLMS_ST_SETTLE = 4'h2,
        CLMS_ST_ARM    = 4'h4,
        CLMS_ST_DONE   = 4'h8
    } clms_step_state_t;

    typedef enum logic [2:0] {
        CLMS_SU_CFG  = 3'h1,
        CLMS_SU_WAIT = 3'h2,
        CLMS_SU_USER = 3'h4
    } clms_startup_state_t;

endpackage

// [rtl/clms_step_engine.sv]
// Dynamic fine shift step engine: accumulates unit steps and reports completion.
// Assumes step edges and reference edges arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "clms_map.svh"

module clms_step_engine
    import clms_pkg::*;
#(
    parameter int SHIFT_W    = 12,
    parameter int SETTLE_REF = `CLMS_SETTLE_REF
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               mgr_rst_i,
    input  wire logic               step_edge_i,
    input  wire logic               step_req_i,
    input  wire logic               step_up_i,
    input  wire logic               ref_edge_i,
    input  wire logic [SHIFT_W-1:0] limit_i,
    output logic signed [SHIFT_W-1:0] shift_o,
    output logic                    complete_o
);

    clms_step_state_t state_ff;
    clms_step_state_t nxt_state;
    logic [7:0]       settle_ff;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Requests seen outside idle and done are dropped: the partner waits for completion
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CLMS_ST_IDLE:   if (step_req_i) nxt_state = CLMS_ST_SETTLE;
            CLMS_ST_SETTLE: if (ref_edge_i && settle_ff == 8'(SETTLE_REF - 1)) nxt_state = CLMS_ST_ARM;
            CLMS_ST_ARM:    if (step_edge_i) nxt_state = CLMS_ST_DONE;
            CLMS_ST_DONE:   if (step_edge_i) nxt_state = step_req_i ? CLMS_ST_SETTLE : CLMS_ST_IDLE;
            default:        nxt_state = CLMS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge mgr_rst_i) begin
        if (mgr_rst_i) begin
            state_ff <= CLMS_ST_IDLE;
        end else if (rst_i) begin
            state_ff <= CLMS_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i or posedge mgr_rst_i) begin
        if (mgr_rst_i) begin
            settle_ff <= 8'h00;
        end else if (rst_i || state_ff != CLMS_ST_SETTLE) begin
            settle_ff <= 8'h00;
        end else if (ref_edge_i) begin
            settle_ff <= settle_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Accumulated shift
    // ----------------------------------------------------------------
    // Step applied on acceptance; saturates at the period-derived limit
    always_ff @(posedge clk_i or posedge mgr_rst_i) begin
        if (mgr_rst_i) begin
            shift_o <= '0;
        end else if (rst_i) begin
            shift_o <= '0;
        end else if (step_req_i && (nxt_state == CLMS_ST_SETTLE) && state_ff != CLMS_ST_SETTLE) begin
            if (step_up_i) begin
                if (shift_o < $signed(limit_i)) shift_o <= shift_o + SHIFT_W'(1);
            end else begin
                if (shift_o > -$signed(limit_i)) shift_o <= shift_o - SHIFT_W'(1);
            end
        end
    end

    // One step clock cycle wide, from one step edge to the next
    assign complete_o = (state_ff == CLMS_ST_DONE);

endmodule
`default_nettype wire

// [bench/clms_checker.sv]
// Port checker for the phase shifter block.
// Assumes it is bound to clms_phase_shifter; everything is sampled on clk_i.
`timescale 1ns/1ps
`default_nettype none
module clms_checker #(
    parameter int SHIFT_W = 12
) (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_ack_o,
    input wire logic                      manager_reset_i,
    input wire logic                      reference_clock_in_i,
    input wire logic                      feedback_clock_in_i,
    input wire logic                      shift_complete_o,
    input wire logic                      phase_lock_flag_o,
    input wire logic [7:0]                status_o,
    input wire logic signed [SHIFT_W-1:0] dynamic_steps_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------
    // Assertions
    // ----------------
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    status_reserved_a: assert property ((status_o & 8'hF9) == 8'h00)
        else $error("reserved bit set");
    mgr_reset_clear_a: assert property (manager_reset_i && $past(manager_reset_i) |->
        dynamic_steps_o == 0 && !phase_lock_flag_o && !shift_complete_o && status_o == 8'h00)
        else $error("state kept in reset");
    // Manager reset zeroes the count at once, so it is left out
    step_unit_a: assert property (disable iff (rst_i || manager_reset_i)
        !$stable(dynamic_steps_o) && !$past(manager_reset_i) |->
        (dynamic_steps_o - $past(dynamic_steps_o)) inside {1, -1})
        else $error("shift jumped");
    complete_quiet_a: assert property (!$stable(dynamic_steps_o) |-> !shift_complete_o)
        else $error("complete during step");
    lone_edge_a: assert property ($rose(reference_clock_in_i) && !$rose(feedback_clock_in_i)
        |-> ##[1:5] !phase_lock_flag_o)
        else $error("lock kept");
    halt_clear_a: assert property ($rose(reference_clock_in_i) |-> ##[1:5] !status_o[1])
        else $error("halt flag kept");
    cover property (wb_ack_o);
    cover property ($rose(shift_complete_o));
    cover property ($rose(phase_lock_flag_o));
    cover property ($rose(status_o[2]));
endmodule
bind clms_phase_shifter clms_checker #(.SHIFT_W(SHIFT_W)) clms_checker_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .manager_reset_i, .reference_clock_in_i,
    .feedback_clock_in_i, .shift_complete_o, .phase_lock_flag_o, .status_o, .dynamic_steps_o);
`default_nettype wire

// [bench/clms_fabric_model.sv]
// Fabric-side model: issues one shift step per go pulse and waits for completion.
// Assumes half_i plus one gives the step clock half period in clk_i cycles.
`timescale 1ns/1ps
`default_nettype none
module clms_fabric_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic       up_i,
    input  wire logic [3:0] half_i,
    input  wire logic       complete_i,
    output logic            en_o,
    output logic            sclk_o,
    output logic            dir_o,
    output logic            busy_o
);
    logic [3:0] cnt_ff;
    logic       seen_ff;
    // ----------------
    // Step sequencing
    // ----------------
    // Step clock rests low between requests
    always_ff @(posedge clk_i) begin
        if (rst_i || !busy_o) begin
            cnt_ff  <= 4'h0;
            seen_ff <= 1'b0;
            sclk_o  <= 1'b0;
            en_o    <= go_i && !rst_i;
            dir_o   <= go_i && up_i && !rst_i;
            busy_o  <= go_i && !rst_i;
        end else if (cnt_ff == half_i) begin
            cnt_ff <= 4'h0;
            sclk_o <= !sclk_o;
            if (sclk_o) begin
                en_o    <= 1'b0;
                dir_o   <= 1'b0;
                seen_ff <= complete_i;
                busy_o  <= !seen_ff;
            end
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [bench/clms_phase_shifter_test.sv]
// Bench: registers, static and dynamic shift, manager reset, lock, status.
// Assumes the fabric model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module clms_phase_shifter_test;
    logic               clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, mrst = 1'b0;
    logic               go = 1'b0, up = 1'b0, refc = 1'b0, ref_run = 1'b1, fb_run = 1'b1, fx_run = 1'b1;
    logic               ack, cpl, lock, usr, en, sclk, dir, busy, cpl_q = 1'b0;
    logic [3:0]         adr = 4'h0, half = 4'h3;
    logic [2:0]         inv = 3'h0;
    logic [1:0]         rdiv = 2'h0;
    logic [31:0]        wdat = 32'h0, rdat, q;
    logic [7:0]         stat;
    logic signed [24:0] sdly;
    logic signed [11:0] steps;
    logic [31:0]        fix[4] = '{32'h40, 32'h1C0, 32'h0, 32'h100};
    int                 dly[4] = '{2000, -2000, 0, -7968};
    int                 fail_count = 0, cmp_count = 0, pulses = 0;

    clms_phase_shifter #(.SETTLE_REF(2), .LOCK_EDGES(2), .HALT_CYCLES(20)) clms_phase_shifter_i (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .manager_reset_i(mrst),
        .reference_clock_in_i(refc), .feedback_clock_in_i(refc & fb_run), .synth_clock_mon_i(rdiv[1] & fx_run),
        .shift_step_enable_i(en ^ inv[0]), .shift_step_clock_i(sclk ^ inv[1]), .shift_direction_i(dir ^ inv[2]),
        .others_phase_lock_flag_i(1'b1), .shift_complete_o(cpl), .phase_lock_flag_o(lock), .status_o(stat),
        .static_delay_ps_o(sdly), .dynamic_steps_o(steps), .user_mode_o(usr));
    clms_fabric_model clms_fabric_model_i (.clk_i(clk), .rst_i(rst), .go_i(go), .up_i(up), .half_i(half),
        .complete_i(cpl), .en_o(en), .sclk_o(sclk), .dir_o(dir), .busy_o(busy));

    // ----------------
    // Clocks, pulse counting, helpers
    // ----------------
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        rdiv <= rdiv + 2'h1;
        cpl_q <= cpl;
        if (rdiv == 2'h3 && ref_run) refc <= !refc;
        if (cpl && !cpl_q) pulses <= pulses + 1;
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check("register read", e, q);
    endtask
    task automatic step(input logic u);
        {go, up} <= {1'b1, u};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        tally_and_finish;
    end
    // ----------------
    // Test sequence
    // ----------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h1F40);
        rd(4'h2, 32'h0);
        check("user mode", 32'h1, {31'h0, usr});
        xfer(1'b1, 4'h0, 32'h1);
        foreach (fix[i]) begin
            xfer(1'b1, 4'h4, fix[i]);
            repeat (2) @(posedge clk);
            check("static delay", dly[i], sdly);
        end
        xfer(1'b0, 4'h4, 32'h0);
        check("fixed clamp", 32'h101, {23'h0, q[8:0]});
        xfer(1'b1, 4'h0, 32'h0);
        repeat (2) @(posedge clk);
        check("static delay off", 32'h0, sdly);
        xfer(1'b1, 4'h0, 32'h2);
        step(1'b1);
        check("dynamic steps", 32'h1, steps);
        step(1'b0);
        step(1'b0);
        check("dynamic steps", 32'hFFFFFFFF, steps);
        // Flip polarity in mode none so it is not taken as a step
        xfer(1'b1, 4'h0, 32'h1C);
        inv <= 3'h7;
        xfer(1'b1, 4'h0, 32'h1E);
        half <= 4'h7;
        step(1'b1);
        check("inverted step", 32'h0, steps);
        xfer(1'b1, 4'h0, 32'h0);
        inv <= 3'h0;
        half <= 4'h3;
        xfer(1'b1, 4'h8, 32'hC1C);
        xfer(1'b1, 4'h0, 32'h2);
        repeat (3) step(1'b1);
        check("saturated steps", 32'h2, steps);
        check("completions", 32'h7, pulses);
        mrst <= 1'b1;
        repeat (30) @(posedge clk);
        check("steps in manager reset", 32'h0, steps);
        mrst <= 1'b0;
        rd(4'h8, 32'hC1C);
        rd(4'h0, 32'h2);
        repeat (60) @(posedge clk);
        rd(4'hC, 32'h300);
        fb_run <= 1'b0;
        repeat (30) @(posedge clk);
        check("lock", 32'h0, {31'h0, lock});
        fb_run <= 1'b1;
        xfer(1'b1, 4'h0, 32'h600);
        ref_run <= 1'b0;
        repeat (40) @(posedge clk);
        check("status", 32'h2, {24'h0, stat});
        ref_run <= 1'b1;
        fx_run <= 1'b0;
        repeat (40) @(posedge clk);
        check("status", 32'h4, {24'h0, stat});
        tally_and_finish;
    end
endmodule
`default_nettype wire
